//--- logic/spb_pkg.sv
// Constants, types and register map of the serial PROM host controller
package spb_pkg;

    // Software register word indices
    localparam logic [2:0] REG_CTRL      = 3'h0;
    localparam logic [2:0] REG_ADDR      = 3'h1;
    localparam logic [2:0] REG_WDATA     = 3'h2;
    localparam logic [2:0] REG_RDATA     = 3'h3;
    localparam logic [2:0] REG_STATUS    = 3'h4;
    localparam logic [2:0] REG_IRQ_STAT  = 3'h5;
    localparam logic [2:0] REG_IRQ_CLEAR = 3'h6;
    localparam logic [2:0] REG_IRQ_EN    = 3'h7;

    // Device register offsets
    localparam logic [4:0] DEV_STATUS_OFS = 5'h09;
    localparam logic [4:0] DEV_PORT_OFS   = 5'h0A;

    // Device field positions
    localparam int PORT_DATA_BIT  = 7;
    localparam int PORT_CLK_BIT   = 0;
    localparam int STAT_FULL_BIT  = 0;
    localparam int STAT_EMPTY_BIT = 1;

    // Commands written to the control register
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_EN   = 3'h1;
    localparam logic [2:0] CMD_DIS  = 3'h2;
    localparam logic [2:0] CMD_WR   = 3'h3;
    localparam logic [2:0] CMD_RD   = 3'h4;
    localparam logic [2:0] CMD_POLL = 3'h5;

    // Serial frame bit patterns and lengths
    localparam logic [8:0] EN_PAT    = 9'h130;
    localparam logic [7:0] DIS_PAT   = 8'h80;
    localparam logic [2:0] WR_OP     = 3'h5;
    localparam logic [2:0] RD_OP     = 3'h6;
    localparam logic [4:0] EN_NBITS  = 5'h09;
    localparam logic [4:0] DIS_NBITS = 5'h08;
    localparam logic [4:0] WR_NBITS  = 5'h19;
    localparam logic [4:0] RD_NBITS  = 5'h09;
    localparam logic [4:0] RD_LAST   = 5'h19;

    // Interrupt status bit positions
    localparam int IRQ_DONE  = 0;
    localparam int IRQ_FULL  = 1;
    localparam int IRQ_EMPTY = 2;

    // Timing of each device port access
    localparam int CLK_NS      = 50;
    localparam int T_SETUP_NS  = 50;
    localparam int T_STROBE_NS = 100;
    localparam int T_GAP_NS    = 100;
    localparam int SYNC_CYC    = 4;
    localparam logic [2:0] SETUP_CYC =
        3'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] STROBE_CYC =
        3'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] GAP_CYC =
        3'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [2:0] READ_CYC = 3'(STROBE_CYC + SYNC_CYC);

    // Access sequencer states
    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_SETUP  = 4'b0010,
        ST_STROBE = 4'b0100,
        ST_GAP    = 4'b1000
    } spb_state_t;

    // Device byte port outputs
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } spb_dev_t;

    // Whole state of the host controller
    typedef struct packed {
        spb_state_t st;
        logic [2:0]  cmd;
        logic [2:0]  cnt;
        logic [4:0]  idx;
        logic [4:0]  nbits;
        logic [4:0]  rlim;
        logic [24:0] seq;
        logic [15:0] rdsh;
        logic [5:0]  addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [7:0]  stat_byte;
        logic [2:0]  irq_st;
        logic [2:0]  irq_en;
        logic        irq;
        logic        waitreq;
        logic [31:0] rdd;
        spb_dev_t    dev;
    } spb_host_st_t;

    localparam spb_host_st_t SPB_RST = '{
        st: ST_IDLE, waitreq: 1'b1, dev: '{addr: DEV_PORT_OFS,
        default: '0}, default: '0};

endpackage

//--- logic/spb_sync3.sv
// Three-stage input synchroniser that accepts a value once stages agree
module spb_sync3 #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset,
    // Raw and settled data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] f1;
        logic [W-1:0] f2;
        logic [W-1:0] f3;
        logic [W-1:0] o;
    } spb_sync_t;

    spb_sync_t s_q;
    spb_sync_t s_d;

    // Shift chain; output moves only when stages two and three agree
    always_comb begin
        s_d    = s_q;
        s_d.f1 = din;
        s_d.f2 = s_q.f1;
        s_d.f3 = s_q.f2;
        if (s_q.f2 == s_q.f3) begin
            s_d.o = s_q.f3;
        end
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign dout = s_q.o;
endmodule

//--- logic/spb_host.sv
// Host controller that bit-bangs the serial PROM through the device port
//
// The Avalon-MM register port was decided locally.
module spb_host (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq,
    // Device byte port
    output spb_pkg::spb_dev_t dev_bus,
    input  wire logic [7:0]  dev_rdata
);
    import spb_pkg::*;

    spb_host_st_t s_q;
    spb_host_st_t s_d;
    logic [7:0]   rd_sync;
    logic         op_read;
    logic         op_bit;
    logic [4:0]   op_ofs;
    logic [7:0]   op_byte;
    logic         req;
    logic         ack;
    logic         idle;

    // Read data from the device crosses in through three stages
    spb_sync3 #(
        .W (8)
    ) u_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .din      (dev_rdata),
        .dout     (rd_sync)
    );

    // Decode of the port access at the current frame position
    always_comb begin
        op_read = 1'b0;
        op_bit  = 1'b0;
        op_ofs  = DEV_PORT_OFS;
        op_byte = 8'h00;
        if (s_q.cmd == CMD_POLL) begin
            op_read = 1'b1;
            op_ofs  = DEV_STATUS_OFS;
        end else if (s_q.idx < s_q.nbits) begin
            op_bit                 = 1'b1;
            op_byte[PORT_DATA_BIT] = s_q.seq[24];
            op_byte[PORT_CLK_BIT]  = 1'b1;
        end else if (s_q.idx < s_q.rlim) begin
            op_read = 1'b1;
        end
    end

    // Bus handshake: one cycle of waitrequest, then a one-cycle answer
    assign req  = avs_read | avs_write;
    assign ack  = req & s_q.waitreq;
    assign idle = (s_q.st == ST_IDLE);

    // Next-state logic
    always_comb begin
        s_d         = s_q;
        s_d.waitreq = ~ack;

        // Register reads
        if (ack && avs_read) begin
            unique case (avs_address)
                REG_ADDR:     s_d.rdd = {26'h0, s_q.addr};
                REG_WDATA:    s_d.rdd = {16'h0, s_q.wdata};
                REG_RDATA:    s_d.rdd = {16'h0, s_q.rdata};
                REG_STATUS:   s_d.rdd = {16'h0, s_q.stat_byte, 7'h0, ~idle};
                REG_IRQ_STAT: s_d.rdd = {29'h0, s_q.irq_st};
                REG_IRQ_EN:   s_d.rdd = {29'h0, s_q.irq_en};
                default:      s_d.rdd = 32'h0;
            endcase
        end

        // Register writes; frame setup is refused while busy
        if (ack && avs_write) begin
            unique case (avs_address)
                REG_ADDR: begin
                    if (idle) begin
                        s_d.addr = avs_writedata[5:0];
                    end
                end
                REG_WDATA: begin
                    if (idle) begin
                        s_d.wdata = avs_writedata[15:0];
                    end
                end
                REG_IRQ_CLEAR: s_d.irq_st = s_q.irq_st & ~avs_writedata[2:0];
                REG_IRQ_EN:    s_d.irq_en = avs_writedata[2:0];
                REG_CTRL: begin
                    if (idle && avs_writedata[2:0] != CMD_NONE
                        && avs_writedata[2:0] <= CMD_POLL) begin
                        s_d.cmd  = avs_writedata[2:0];
                        s_d.idx  = 5'h00;
                        s_d.rdsh = 16'h0000;
                        s_d.st   = ST_SETUP;
                        s_d.cnt  = SETUP_CYC;
                        s_d.seq  = 25'h0;
                        unique case (avs_writedata[2:0])
                            CMD_EN: begin
                                s_d.seq   = {EN_PAT, 16'h0000};
                                s_d.nbits = EN_NBITS;
                                s_d.rlim  = EN_NBITS;
                            end
                            CMD_DIS: begin
                                s_d.seq   = {DIS_PAT, 17'h0};
                                s_d.nbits = DIS_NBITS;
                                s_d.rlim  = DIS_NBITS;
                            end
                            CMD_WR: begin
                                // Start, opcode, address, data
                                s_d.seq   = {WR_OP, s_q.addr, s_q.wdata};
                                s_d.nbits = WR_NBITS;
                                s_d.rlim  = WR_NBITS;
                            end
                            CMD_RD: begin
                                s_d.seq   = {RD_OP, s_q.addr, 16'h0000};
                                s_d.nbits = RD_NBITS;
                                s_d.rlim  = RD_LAST;
                            end
                            default: begin
                                s_d.nbits = 5'h00;
                                s_d.rlim  = 5'h00;
                            end
                        endcase
                    end
                end
                default: ;
            endcase
        end

        // Port access sequencer
        unique case (s_q.st)
            ST_IDLE: begin
                s_d.dev.wr = 1'b0;
                s_d.dev.rd = 1'b0;
            end
            ST_SETUP: begin
                // Address and byte settle before the strobe
                s_d.dev.addr  = op_ofs;
                s_d.dev.wdata = op_byte;
                if (s_q.cnt == 3'h0) begin
                    s_d.st     = ST_STROBE;
                    s_d.dev.wr = ~op_read;
                    s_d.dev.rd = op_read;
                    s_d.cnt    = op_read ? READ_CYC - 3'h1
                                         : STROBE_CYC - 3'h1;
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_STROBE: begin
                if (s_q.cnt == 3'h0) begin
                    s_d.dev.wr = 1'b0;
                    s_d.dev.rd = 1'b0;
                    s_d.st     = ST_GAP;
                    s_d.cnt    = GAP_CYC - 3'h1;
                    if (op_read && s_q.cmd == CMD_POLL) begin
                        // Reading clears the device flags, so keep them
                        s_d.stat_byte = rd_sync;
                        if (rd_sync[STAT_FULL_BIT]) begin
                            s_d.irq_st[IRQ_FULL] = 1'b1;
                        end
                        if (rd_sync[STAT_EMPTY_BIT]) begin
                            s_d.irq_st[IRQ_EMPTY] = 1'b1;
                        end
                    end else if (op_read) begin
                        // Bits arrive from D15 down to D0
                        s_d.rdsh = {s_q.rdsh[14:0], rd_sync[PORT_DATA_BIT]};
                    end
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
            ST_GAP: begin
                if (s_q.cnt == 3'h0) begin
                    if (s_q.idx == s_q.rlim) begin
                        s_d.st               = ST_IDLE;
                        s_d.irq_st[IRQ_DONE] = 1'b1;
                        if (s_q.cmd == CMD_RD) begin
                            s_d.rdata = s_q.rdsh;
                        end
                    end else begin
                        s_d.idx = s_q.idx + 5'h01;
                        s_d.st  = ST_SETUP;
                        s_d.cnt = SETUP_CYC;
                        if (op_bit) begin
                            s_d.seq = {s_q.seq[23:0], 1'b0};
                        end
                    end
                end else begin
                    s_d.cnt = s_q.cnt - 3'h1;
                end
            end
        endcase

        // Level interrupt from enabled sticky bits
        s_d.irq = |(s_d.irq_st & s_d.irq_en);
    end

    // State register
    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= SPB_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign avs_readdata    = s_q.rdd;
    assign avs_waitrequest = s_q.waitreq;
    assign irq             = s_q.irq;
    assign dev_bus         = s_q.dev;

    // Checks on the frames driven to the device
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    property p_port_byte_form;
        s_q.dev.wr && s_q.dev.addr == DEV_PORT_OFS && s_q.dev.wdata != 8'h00
            |-> s_q.dev.wdata[6:0] == 7'h01;
    endproperty
    a_port_byte_form: assert property (p_port_byte_form)
        else $error("port byte has stray bits or clock low");

    property p_frame_ends_zero;
        s_q.st == ST_IDLE && $past(s_q.st) == ST_GAP
            && s_q.cmd != CMD_POLL |-> s_q.dev.wdata == 8'h00;
    endproperty
    a_frame_ends_zero: assert property (p_frame_ends_zero)
        else $error("frame did not end with byte 00");

    property p_enable_frame;
        s_q.cmd == CMD_EN && s_q.dev.wr |->
            s_q.dev.wdata == ((s_q.idx == 5'h00 || s_q.idx == 5'h03
            || s_q.idx == 5'h04) ? 8'h81 : (s_q.idx == 5'h09) ? 8'h00
            : 8'h01);
    endproperty
    a_enable_frame: assert property (p_enable_frame)
        else $error("enable frame byte wrong");

    property p_disable_frame;
        s_q.cmd == CMD_DIS && s_q.dev.wr |-> s_q.dev.wdata ==
            ((s_q.idx == 5'h00) ? 8'h81 : (s_q.idx == 5'h08) ? 8'h00
            : 8'h01);
    endproperty
    a_disable_frame: assert property (p_disable_frame)
        else $error("disable frame byte wrong");

    property p_write_opening;
        s_q.cmd == CMD_WR && s_q.dev.wr && s_q.idx < 5'h03 |->
            s_q.dev.wdata == ((s_q.idx == 5'h01) ? 8'h01 : 8'h81);
    endproperty
    a_write_opening: assert property (p_write_opening)
        else $error("word write opening bytes wrong");

    property p_write_msb_first;
        s_q.cmd == CMD_WR && s_q.dev.wr |->
            (s_q.idx < 5'h03 || s_q.idx > 5'h08
             || s_q.dev.wdata[7] == s_q.addr[3'(5'h08 - s_q.idx)])
            && (s_q.idx < 5'h09 || s_q.idx > 5'h18
             || s_q.dev.wdata[7] == s_q.wdata[4'(5'h18 - s_q.idx)]);
    endproperty
    a_write_msb_first: assert property (p_write_msb_first)
        else $error("word write bit order wrong");

    property p_read_slots;
        s_q.cmd == CMD_RD && s_q.dev.rd |-> s_q.idx >= 5'h09
            && s_q.idx <= 5'h18 && s_q.dev.addr == DEV_PORT_OFS;
    endproperty
    a_read_slots: assert property (p_read_slots)
        else $error("read strobe outside the sixteen read slots");

    property p_write_length;
        s_q.st == ST_IDLE && $past(s_q.st) == ST_GAP
            && s_q.cmd == CMD_WR |-> $past(s_q.idx) == 5'h19;
    endproperty
    a_write_length: assert property (p_write_length)
        else $error("word write frame not 26 accesses");

    property p_strobe_setup;
        $rose(s_q.dev.wr) |-> $stable(s_q.dev.addr)
            && $stable(s_q.dev.wdata) && !s_q.dev.rd;
    endproperty
    a_strobe_setup: assert property (p_strobe_setup)
        else $error("byte changed as the write strobe rose");
endmodule

//--- sim/spb_dev_model.sv
// Behavioural model of the card's status register and PROM byte port
module spb_dev_model (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              reset,
    // Byte port driven by the host
    input  wire spb_pkg::spb_dev_t dev_bus,
    output logic [7:0]             dev_rdata,
    // Acquisition events and the word the PROM hands back
    input  wire logic              fifo_full,
    input  wire logic              empty_rd,
    input  wire logic [15:0]       rd_word,
    // Serial lines toward the PROM
    output logic                   serial_data,
    output logic                   serial_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    import spb_pkg::*;
    logic [7:0]  wlog[$];
    logic [4:0]  n_rd;
    logic [15:0] shw;
    logic        wr_q;
    logic        rd_q;
    logic        fifo_full_sticky_flag;
    logic        empty_read_error_flag;

    // Next PROM bit leaves most significant first
    assign shw = rd_word << n_rd;

    // Port writes, flag upkeep and read answers
    always @(posedge core_clk) begin
        wr_q <= dev_bus.wr;
        rd_q <= dev_bus.rd;
        if (reset) begin
            n_rd        <= 5'h00;
            fifo_full_sticky_flag <= 1'b0;
            empty_read_error_flag <= 1'b0;
            serial_data <= 1'b0;
            serial_clk  <= 1'b0;
            dev_rdata   <= 8'h00;
        end else begin
            // End of a read: status clears, PROM steps one bit
            if (rd_q && !dev_bus.rd) begin
                if (dev_bus.addr == DEV_STATUS_OFS) begin
                    fifo_full_sticky_flag <= 1'b0;
                    empty_read_error_flag <= 1'b0;
                end else begin
                    n_rd <= n_rd + 5'h01;
                end
                dev_rdata <= ~dev_rdata; // Released bus shows no stale value
            end
            // Events set the sticky flags and win over a clear
            if (fifo_full) fifo_full_sticky_flag <= 1'b1;
            if (empty_rd) empty_read_error_flag <= 1'b1;
            // Only bits 7 and 0 of a port byte reach the PROM
            if (dev_bus.wr && !wr_q && dev_bus.addr == DEV_PORT_OFS) begin
                wlog.push_back(dev_bus.wdata);
                serial_data <= dev_bus.wdata[PORT_DATA_BIT];
                serial_clk  <= dev_bus.wdata[PORT_CLK_BIT];
                n_rd        <= 5'h00;
            end
            // Answer one cycle after the strobe rises, held to its end
            if (dev_bus.rd && !rd_q) begin
                if (dev_bus.addr == DEV_STATUS_OFS)
                    dev_rdata <= {6'h00, empty_read_error_flag,
                                  fifo_full_sticky_flag};
                else
                    dev_rdata <= {shw[15], 7'h00};
            end
        end
    end
endmodule

//--- sim/tb_serial_prom_bitbang_port.sv
// Self-checking bench for the serial PROM host controller
module tb_serial_prom_bitbang_port;
    timeunit 1ns;
    timeprecision 1ns;
    import spb_pkg::*;
    typedef logic [7:0] spb_byteq_t[$];

    logic        core_clk;
    logic        reset;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    spb_dev_t    dev_bus;
    logic [7:0]  dev_rdata;
    logic        fifo_full;
    logic        empty_rd;
    logic [15:0] prom_word;
    logic        serial_data;
    logic        serial_clk;
    int          failures;
    int          n_tests;

    // 20 MHz bus clock
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    spb_host i_dut (
        .core_clk(core_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq),
        .dev_bus(dev_bus), .dev_rdata(dev_rdata));

    spb_dev_model i_dev (
        .core_clk(core_clk), .reset(reset), .dev_bus(dev_bus),
        .dev_rdata(dev_rdata), .fifo_full(fifo_full), .empty_rd(empty_rd),
        .rd_word(prom_word), .serial_data(serial_data),
        .serial_clk(serial_clk));

    // Report counts and verdict, then stop
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // A wait that ran out ends the run
    task automatic timeout();
        failures++;
        $display("Timeout at %0t", $time);
        wrap_up();
    endtask

    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [2:0] a,
                           input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        if (avs_waitrequest !== 1'b0) timeout();
    endtask

    task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, d, q);
    endtask

    task automatic av_rd(input logic [2:0] a, output logic [31:0] q);
        av_xfer(1'b0, a, 32'h0, q);
    endtask

    // Clear the byte log and launch a frame
    task automatic start(input logic [2:0] cmd);
        i_dev.wlog.delete();
        av_wr(REG_CTRL, 32'(cmd));
    endtask

    // Poll the busy bit under a bound
    task automatic wait_idle();
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            av_rd(REG_STATUS, q);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (q[0] !== 1'b0) timeout();
    endtask

    // Compare the port bytes seen by the device with a list
    task automatic chk_log(input spb_byteq_t e);
        chk(32'(i_dev.wlog.size()), 32'(e.size()));
        foreach (e[i]) chk(32'(i_dev.wlog[i]), 32'(e[i]));
    endtask

    function automatic logic [7:0] bb(input logic b);
        return (b === 1'b1) ? 8'h81 : 8'h01;
    endfunction

    task automatic poll(input logic [7:0] exp);
        logic [31:0] q;
        start(CMD_POLL);
        wait_idle();
        av_rd(REG_STATUS, q);
        chk(32'(q[15:8]), 32'(exp));
    endtask

    task automatic t_reset();
        logic [31:0] q;
        chk(32'(irq), 32'h0);
        chk(32'(dev_bus), 32'({DEV_PORT_OFS, 8'h00, 2'b00}));
        av_rd(REG_IRQ_STAT, q);
        chk(q, 32'h0);
        av_rd(REG_CTRL, q);
        chk(q, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_enable();
        logic [31:0] q;
        spb_byteq_t  e;
        e = {8'h81, 8'h01, 8'h01, 8'h81, 8'h81,
             8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
        start(CMD_EN);
        wait_idle();
        chk_log(e);
        av_rd(REG_IRQ_STAT, q);
        chk(q, 32'h1);
        av_wr(REG_IRQ_CLEAR, 32'h1);
        av_rd(REG_IRQ_STAT, q);
        chk(q, 32'h0);
        $display("t_enable done");
    endtask

    task automatic t_word_write(input logic [5:0] a, input logic [15:0] d);
        spb_byteq_t  e;
        logic [31:0] q;
        e = {8'h81, 8'h01, 8'h81};
        for (int i = 5; i >= 0; i--) e.push_back(bb(a[i]));
        for (int i = 15; i >= 0; i--) e.push_back(bb(d[i]));
        e.push_back(8'h00);
        av_wr(REG_ADDR, 32'(a));
        av_wr(REG_WDATA, 32'(d));
        start(CMD_WR);
        av_wr(REG_ADDR, 32'(~a)); // Refused while busy
        av_wr(REG_CTRL, 32'(CMD_EN)); // Refused while busy
        wait_idle();
        chk_log(e);
        av_rd(REG_ADDR, q);
        chk(q, 32'(a));
        av_rd(REG_WDATA, q);
        chk(q, 32'(d));
        chk(32'({serial_data, serial_clk}), 32'h0);
        $display("t_word_write done");
    endtask

    task automatic t_disable();
        logic [31:0] q;
        spb_byteq_t  e;
        e = {8'h81, 8'h01, 8'h01, 8'h01, 8'h01,
             8'h01, 8'h01, 8'h01, 8'h00};
        start(CMD_DIS);
        wait_idle();
        chk_log(e);
        av_wr(REG_CTRL, 32'h7); // Undefined code starts nothing
        av_rd(REG_STATUS, q);
        chk(32'(q[0]), 32'h0);
        $display("t_disable done");
    endtask

    task automatic t_word_read();
        spb_byteq_t  e;
        logic [31:0] q;
        logic [5:0]  a;
        a = 6'h2A;
        e = {8'h81, 8'h81, 8'h01};
        for (int i = 5; i >= 0; i--) e.push_back(bb(a[i]));
        e.push_back(8'h00);
        prom_word <= 16'hC3A5;
        av_wr(REG_ADDR, 32'(a));
        start(CMD_RD);
        wait_idle();
        chk_log(e);
        av_rd(REG_RDATA, q);
        chk(q, 32'h0000C3A5);
        av_wr(REG_RDATA, 32'h0);
        av_rd(REG_RDATA, q);
        chk(q, 32'h0000C3A5);
        $display("t_word_read done");
    endtask

    task automatic t_flags();
        logic [31:0] q;
        av_wr(REG_IRQ_EN, 32'h7);
        av_rd(REG_IRQ_EN, q);
        chk(q, 32'h7);
        fifo_full <= 1'b1;
        empty_rd  <= 1'b1;
        @(posedge core_clk);
        fifo_full <= 1'b0;
        empty_rd  <= 1'b0;
        poll(8'h03);
        av_rd(REG_IRQ_STAT, q);
        chk(q, 32'h7);
        chk(32'(irq), 32'h1);
        fifo_full <= 1'b1;
        poll(8'h01);
        fifo_full <= 1'b0;
        poll(8'h01);
        poll(8'h00);
        av_wr(REG_IRQ_EN, 32'h0);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        av_wr(REG_IRQ_EN, 32'h7);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h1);
        av_wr(REG_IRQ_CLEAR, 32'h7);
        repeat (2) @(posedge core_clk);
        chk(32'(irq), 32'h0);
        av_rd(REG_IRQ_STAT, q);
        chk(q, 32'h0);
        $display("t_flags done");
    endtask

    // Main sequence
    initial begin
        reset         = 1'b1;
        avs_address   = 3'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        fifo_full     = 1'b0;
        empty_rd      = 1'b0;
        prom_word     = 16'h0;
        failures      = 0;
        n_tests       = 0;
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        t_reset();
        t_enable();
        t_word_write(6'h05, 16'hAA55);
        t_word_write(6'h3F, 16'h8001);
        t_disable();
        t_word_read();
        t_flags();
        wrap_up();
    end
endmodule
